/* msirq_regs.svh */
// constants for the multi-source interrupt combiner
`ifndef MSIRQ_REGS_SVH
`define MSIRQ_REGS_SVH
`define MSIRQ_NSRC 8
`define MSIRQ_NCHAN 4
`define MSIRQ_LVL_W 3
`define MSIRQ_ACK_ADDR 20'h00000
`define MSIRQ_ADDR_W 20
`define MSIRQ_HOLD_CYCLES 5
`define MSIRQ_CNT_W 3
`define MSIRQ_CNT_ZERO 3'h0
`define MSIRQ_SRC_ZERO 8'h00
`define MSIRQ_CHAN_ZERO 4'h0
`define MSIRQ_LVL_ZERO 3'h0
`endif

/* msirq_pkg.sv */
// types for the multi-source interrupt combiner
`include "msirq_regs.svh"
package msirq_pkg;
    typedef logic [`MSIRQ_NSRC-1:0] msirq_src_t;
    typedef logic [`MSIRQ_LVL_W-1:0] msirq_lvl_t;
    typedef struct packed {
        msirq_src_t status;
        msirq_src_t enable;
    } msirq_srcgrp_t;
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        msirq_lvl_t level;
    } msirq_ack_t;
    typedef enum logic [1:0] {
        MSIRQ_FOLLOW = 2'b00,
        MSIRQ_HOLD = 2'b01
    } msirq_state_t;
endpackage

/* msirq_chan.sv */
// one combined request flag with write-zero hold and clear-on-read
`timescale 1ns/1ps
module msirq_chan
    import msirq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // sources
    input wire msirq_srcgrp_t src_i,
    // software and acknowledge events
    input wire logic flag_wr0_i,
    input wire logic read_clr_i,
    input wire logic reconfig_i,
    // result
    output logic request_flag_o
);
    msirq_state_t state_r, state_nxt;
    logic [`MSIRQ_CNT_W-1:0] cnt_r, cnt_nxt;
    logic flag_r, flag_nxt;
    logic spur_r, spur_nxt;
    wire logic any_active = |(src_i.status & src_i.enable);
    wire logic clr_evt = flag_wr0_i | read_clr_i;
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        // spurious set on reconfiguration, cleared by software
        spur_nxt = reconfig_i ? 1'b1 : (clr_evt ? 1'b0 : spur_r);
        case (state_r)
            MSIRQ_FOLLOW: begin
                if (clr_evt && any_active) begin
                    state_nxt = MSIRQ_HOLD;
                    cnt_nxt = `MSIRQ_CNT_W'(`MSIRQ_HOLD_CYCLES - 1);
                end
            end
            MSIRQ_HOLD: begin
                if (clr_evt && any_active) begin
                    // a further zero write or read-clear while a source is active restarts the window
                    cnt_nxt = `MSIRQ_CNT_W'(`MSIRQ_HOLD_CYCLES - 1);
                end else if (cnt_r == `MSIRQ_CNT_ZERO) begin
                    state_nxt = MSIRQ_FOLLOW;
                end else begin
                    cnt_nxt = cnt_r - `MSIRQ_CNT_W'(1);
                end
            end
            default: begin
                state_nxt = MSIRQ_FOLLOW;
            end
        endcase
        // no latching: flag follows the gated OR outside the hold window
        flag_nxt = (state_nxt == MSIRQ_FOLLOW) & (any_active | spur_nxt);
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= MSIRQ_FOLLOW;
            cnt_r <= `MSIRQ_CNT_ZERO;
            flag_r <= 1'b0;
            spur_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
            spur_r <= spur_nxt;
        end
    end
    assign request_flag_o = flag_r;
endmodule

/* msirq_top.sv */
// combiner of multi-source peripheral interrupts with acknowledge logic
// Operation
// - each request is the OR of its sources, each gated by its enable bit
// - outside the hold window, flag goes high whenever some source has status and enable both set
// - request is not latched; flag drops when no source is active
// - writing zero to an active flag holds it low five cycles, then sets again
// - acknowledge leaves source status bits unchanged
// - acknowledge clears the combined flag of the selected channel only
// - further sources becoming active keep the flag high
// - acceptance only via global enable, flag, three-bit level field and processor level
// - acknowledge read of address zero returns number and level, clears flag
// - any program read of address zero clears highest-priority pending flag
// - reconfiguration may set the flag; software clears it afterwards
`timescale 1ns/1ps
module msirq_top
    import msirq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // peripheral source events, one pulse per source
    input wire msirq_src_t timer_c_set_i,
    input wire msirq_src_t timer_e_set_i,
    input wire msirq_src_t serial_set_i,
    input wire msirq_src_t flash_set_i,
    // software writes to source status (clear mask) and enable
    input wire logic [`MSIRQ_NCHAN-1:0] status_clr_we_i,
    input wire logic [`MSIRQ_NCHAN-1:0] enable_we_i,
    input wire msirq_src_t wdata_i,
    // software writes zero to a request flag, reconfiguration strobes
    input wire logic [`MSIRQ_NCHAN-1:0] flag_wr0_i,
    input wire logic [`MSIRQ_NCHAN-1:0] reconfig_i,
    // priority level field per channel and processor level
    input wire msirq_lvl_t timer_c_level_i,
    input wire msirq_lvl_t timer_e_level_i,
    input wire msirq_lvl_t serial_level_i,
    input wire msirq_lvl_t flash_level_i,
    input wire msirq_lvl_t processor_priority_level_i,
    input wire logic irq_global_en_i,
    // read of the acknowledge information address
    input wire logic rd_i,
    input wire logic [`MSIRQ_ADDR_W-1:0] rd_addr_i,
    // state toward software and cpu
    output msirq_src_t timer_c_source_status_o,
    output msirq_src_t timer_c_source_enable_o,
    output msirq_src_t timer_e_source_status_o,
    output msirq_src_t timer_e_source_enable_o,
    output msirq_src_t serial_source_status_o,
    output msirq_src_t serial_source_enable_o,
    output msirq_src_t flash_source_status_o,
    output msirq_src_t flash_source_enable_o,
    output logic [`MSIRQ_NCHAN-1:0] request_flag_o,
    output logic irq_req_o,
    output msirq_ack_t ack_info_o
);
    msirq_src_t status_r [`MSIRQ_NCHAN];
    msirq_src_t enable_r [`MSIRQ_NCHAN];
    msirq_src_t set_w [`MSIRQ_NCHAN];
    msirq_lvl_t lvl_w [`MSIRQ_NCHAN];
    logic [`MSIRQ_NCHAN-1:0] flag_w;
    logic [`MSIRQ_NCHAN-1:0] rdclr_w;
    logic irq_req_r;
    msirq_ack_t ack_r;

    assign set_w[0] = timer_c_set_i;
    assign set_w[1] = timer_e_set_i;
    assign set_w[2] = serial_set_i;
    assign set_w[3] = flash_set_i;
    assign lvl_w[0] = timer_c_level_i;
    assign lvl_w[1] = timer_e_level_i;
    assign lvl_w[2] = serial_level_i;
    assign lvl_w[3] = flash_level_i;

    // set wins over a software clear of the same bit
    function automatic msirq_src_t status_next(input msirq_src_t cur, input msirq_src_t set,
                                               input logic clr_we, input msirq_src_t clr_mask);
        status_next = (clr_we ? (cur & ~clr_mask) : cur) | set;
    endfunction

    // highest-priority enabled pending channel; lower index wins ties
    logic [1:0] best_chan_w;
    msirq_lvl_t best_lvl_w;
    logic best_valid_w;
    always_comb begin
        best_chan_w = 2'h0;
        best_lvl_w = `MSIRQ_LVL_ZERO;
        best_valid_w = 1'b0;
        for (int i = `MSIRQ_NCHAN - 1; i >= 0; i--) begin
            if (flag_w[i] && lvl_w[i] != `MSIRQ_LVL_ZERO && lvl_w[i] >= best_lvl_w) begin
                best_chan_w = 2'(i);
                best_lvl_w = lvl_w[i];
                best_valid_w = 1'b1;
            end
        end
    end
    // maskable path: flag, level field above processor level
    wire logic accept_w = irq_global_en_i & best_valid_w & (best_lvl_w > processor_priority_level_i);
    wire logic ack_rd_w = rd_i & (rd_addr_i == `MSIRQ_ACK_ADDR);
    // read clears only the flag, never statuses
    assign rdclr_w = (ack_rd_w & best_valid_w) ? (`MSIRQ_NCHAN'(1) << best_chan_w) : `MSIRQ_CHAN_ZERO;

    genvar g;
    generate
        for (g = 0; g < `MSIRQ_NCHAN; g++) begin : gen_chan
            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    status_r[g] <= `MSIRQ_SRC_ZERO;
                    enable_r[g] <= `MSIRQ_SRC_ZERO;
                end else begin
                    // acknowledge has no path into status
                    status_r[g] <= status_next(status_r[g], set_w[g], status_clr_we_i[g], wdata_i);
                    if (enable_we_i[g]) begin
                        enable_r[g] <= wdata_i;
                    end
                end
            end
            msirq_chan u_chan (
                .ref_clk_i(ref_clk_i),
                .resetn_i(resetn_i),
                .src_i('{status: status_r[g], enable: enable_r[g]}),
                .flag_wr0_i(flag_wr0_i[g]),
                .read_clr_i(rdclr_w[g]),
                .reconfig_i(reconfig_i[g]),
                .request_flag_o(flag_w[g])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_req_r <= 1'b0;
            ack_r <= '0;
        end else begin
            irq_req_r <= accept_w;
            if (ack_rd_w) begin
                ack_r <= '{valid: best_valid_w, chan: best_chan_w, level: best_lvl_w};
            end
        end
    end

    assign timer_c_source_status_o = status_r[0];
    assign timer_c_source_enable_o = enable_r[0];
    assign timer_e_source_status_o = status_r[1];
    assign timer_e_source_enable_o = enable_r[1];
    assign serial_source_status_o = status_r[2];
    assign serial_source_enable_o = enable_r[2];
    assign flash_source_status_o = status_r[3];
    assign flash_source_enable_o = enable_r[3];
    assign request_flag_o = flag_w;
    assign irq_req_o = irq_req_r;
    assign ack_info_o = ack_r;
endmodule

/* msirq_top_sva.sv */
// port assertions for the interrupt combiner
`timescale 1ns/1ps
module msirq_top_sva
    import msirq_pkg::*;
(
    // ports watched
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire msirq_src_t timer_c_set_i,
    input wire logic [3:0] status_clr_we_i,
    input wire logic [3:0] flag_wr0_i,
    input wire logic [3:0] reconfig_i,
    input wire logic irq_global_en_i,
    input wire logic rd_i,
    input wire logic [19:0] rd_addr_i,
    input wire msirq_src_t timer_c_source_status_o,
    input wire msirq_src_t timer_c_source_enable_o,
    input wire logic [3:0] request_flag_o,
    input wire logic irq_req_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [2:0] quiet_r;
    logic recfg_r;
    wire act0 = |(timer_c_source_status_o & timer_c_source_enable_o);
    wire ev0 = flag_wr0_i[0] || (rd_i && rd_addr_i == 20'h00000);
    // any address-zero read may pick channel 0, so count conservatively
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            quiet_r <= 3'h0;
            recfg_r <= 1'h0;
        end else begin
            quiet_r <= ev0 ? 3'h0 : quiet_r + 3'(quiet_r != 3'h7);
            recfg_r <= recfg_r | reconfig_i[0];
        end
    end
    sequence s_wr0; flag_wr0_i[0] && act0; endsequence
    sequence s_calm; (act0 && !ev0) [*5]; endsequence
    a_status_sets: assert property (timer_c_set_i != 8'h00 |=>
        (timer_c_source_status_o & $past(timer_c_set_i)) == $past(timer_c_set_i)) else $error("status set lost");
    a_flag_follows: assert property (act0 && !ev0 && quiet_r >= 3'h5 |=> request_flag_o[0])
        else $error("flag not raised");
    a_no_latch: assert property (!act0 && !recfg_r && !reconfig_i[0] |=> !request_flag_o[0])
        else $error("flag latched");
    a_hold_low: assert property (s_wr0 |=> !request_flag_o[0] [*5]) else $error("hold too short");
    a_hold_release: assert property (s_wr0 ##1 s_calm |=> request_flag_o[0]) else $error("flag not back");
    a_ack_keeps: assert property (ev0 && !flag_wr0_i[0] && timer_c_set_i == 8'h00 && !status_clr_we_i[0]
        |=> $stable(timer_c_source_status_o)) else $error("status changed on read");
    a_irq_gate: assert property (!irq_global_en_i |=> !irq_req_o) else $error("irq while disabled");
    a_irq_cause: assert property (irq_req_o |-> $past(request_flag_o) != 4'h0) else $error("irq w/o flag");
endmodule
bind msirq_top msirq_top_sva u_sva (.ref_clk_i, .resetn_i, .timer_c_set_i, .status_clr_we_i, .flag_wr0_i,
    .reconfig_i, .irq_global_en_i, .rd_i, .rd_addr_i, .timer_c_source_status_o, .timer_c_source_enable_o,
    .request_flag_o, .irq_req_o);

/* msirq_cpu_model.sv */
// cpu side: reads address zero to acknowledge a request
`timescale 1ns/1ps
module msirq_cpu_model (
    // clock, reset, requests
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic irq_req_i,
    input wire logic slow_i,
    input wire logic prog_rd_i,
    input wire logic [19:0] prog_addr_i,
    // read toward combiner
    output logic rd_o,
    output logic [19:0] rd_addr_o
);
    logic [4:0] gap_r;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {rd_o, rd_addr_o, gap_r} <= '0;
        end else if (rd_o) begin
            rd_o <= 1'h0;
            rd_addr_o <= ~rd_addr_o; // released bus shows no stale address
        end else if (gap_r != 5'h0) begin
            gap_r <= gap_r - 5'h1;
        end else if (irq_req_i) begin
            rd_o <= 1'h1;
            rd_addr_o <= 20'h00000;
            gap_r <= slow_i ? 5'h14 : 5'h7; // gap of 7 or 20 cycles outlasts the five-cycle flag hold
        end else if (prog_rd_i) begin
            rd_o <= 1'h1;
            rd_addr_o <= prog_addr_i;
        end
    end
endmodule

/* tb_top.sv */
// random bench: combiner against a behavioural model
`timescale 1ns/1ps
module tb_top;
    import msirq_pkg::*;
    logic ref_clk_i = 1'h0, resetn_i = 1'h0, gen = 1'h0, slow = 1'h0, prd = 1'h0, rd, irq, irq_x;
    logic [3:0] clr_we = '0, en_we = '0, wr0 = '0, recfg = '0, fl_o, fl, spur;
    logic [19:0] paddr = '0, raddr;
    logic [31:0] r, q;
    msirq_src_t wdata = '0, set[4] = '{default: 0}, st_o[4], en_o[4], st[4], en[4];
    msirq_lvl_t ppl = '0, lvl[4] = '{default: 0};
    msirq_ack_t ack, ack_x;
    int fails = 0, compares = 0, seed = 32'h078f4a27, cyc = 0, hold[4];
    msirq_top dut (.ref_clk_i, .resetn_i, .timer_c_set_i(set[0]), .timer_e_set_i(set[1]), .serial_set_i(set[2]),
        .flash_set_i(set[3]), .status_clr_we_i(clr_we), .enable_we_i(en_we), .wdata_i(wdata), .flag_wr0_i(wr0),
        .reconfig_i(recfg), .timer_c_level_i(lvl[0]), .timer_e_level_i(lvl[1]), .serial_level_i(lvl[2]),
        .flash_level_i(lvl[3]), .processor_priority_level_i(ppl), .irq_global_en_i(gen), .rd_i(rd),
        .rd_addr_i(raddr), .timer_c_source_status_o(st_o[0]), .timer_c_source_enable_o(en_o[0]),
        .timer_e_source_status_o(st_o[1]), .timer_e_source_enable_o(en_o[1]), .serial_source_status_o(st_o[2]),
        .serial_source_enable_o(en_o[2]), .flash_source_status_o(st_o[3]), .flash_source_enable_o(en_o[3]),
        .request_flag_o(fl_o), .irq_req_o(irq), .ack_info_o(ack));
    msirq_cpu_model cpu (.ref_clk_i, .resetn_i, .irq_req_i(irq), .slow_i(slow), .prog_rd_i(prd),
        .prog_addr_i(paddr), .rd_o(rd), .rd_addr_o(raddr));
    initial forever #10 ref_clk_i = ~ref_clk_i;
    // ties go to the lowest index
    function automatic int best(input logic [3:0] f);
        best = -1;
        for (int c = 3; c >= 0; c--) if (f[c] && lvl[c] != 3'h0 && (best < 0 || lvl[c] >= lvl[best])) best = c;
    endfunction
    always @(posedge ref_clk_i or negedge resetn_i) begin
        int b;
        if (!resetn_i) begin
            {fl, spur, irq_x, ack_x} = '0;
            st = '{default: 0};
            en = '{default: 0};
            hold = '{default: 0};
        end else begin
            b = (rd && raddr == 20'h00000) ? best(fl) : -1;
            if (rd && raddr == 20'h00000) ack_x = b < 0 ? '0 : {1'h1, 2'(b), lvl[b]};
            irq_x = gen && best(fl) >= 0 && lvl[best(fl)] > ppl;
            for (int c = 0; c < 4; c++) begin
                logic act;
                act = |(st[c] & en[c]);
                // a reconfiguration in the same cycle as a clear wins
                if (recfg[c]) spur[c] = 1'h1;
                else if (wr0[c] || b == c) spur[c] = 1'h0;
                if ((wr0[c] || b == c) && act) hold[c] = 5;
                fl[c] = hold[c] == 0 && (act || spur[c]);
                if (hold[c] > 0) hold[c]--;
                st[c] = (st[c] & ~(clr_we[c] ? wdata : 8'h00)) | set[c];
                if (en_we[c]) en[c] = wdata;
            end
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(negedge ref_clk_i) if (resetn_i) begin
        for (int c = 0; c < 4; c++) begin
            check(st_o[c], st[c]);
            check(en_o[c], en[c]);
        end
        check(8'(fl_o), 8'(fl));
        check(8'(irq), 8'(irq_x));
        check(8'(ack), 8'(ack_x));
        if (++cyc > 5000) begin
            fails++;
            summarize;
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        resetn_i <= 1'h1;
        for (int ph = 0; ph < 8; ph++) begin
            for (int n = 0; n < 400; n++) begin
                @(posedge ref_clk_i);
                r = $random(seed);
                q = $random(seed);
                if (n == 0) begin
                    gen <= ph != 2;
                    slow <= ph[0];
                    ppl <= ph[2:0];
                    for (int c = 0; c < 4; c++) lvl[c] <= 3'(r >> (3 * c));
                end
                for (int c = 0; c < 4; c++) set[c] <= ($random(seed) & 7) == 0 ? 8'h01 << ($random(seed) & 7) : 8'h00;
                clr_we <= r[3:0] & r[7:4] & r[11:8];
                en_we <= r[15:12] & r[19:16] & r[23:20];
                wdata <= r[31:24];
                wr0 <= q[3:0] & q[7:4] & q[11:8];
                recfg <= {q[15:12] == 4'h0 && !(q[3] & q[7] & q[11]), 3'h0};
                prd <= q[19:16] == 4'h0;
                paddr <= q[20] ? 20'h00000 : 20'(q[31:21]);
            end
        end
        summarize;
    end
endmodule
